// File: sfwc_pkg.sv
`default_nettype none

package sfwc_pkg;

    // Reference clock
    localparam int CLK_NS      = 10;

    // Bus shape of the flash part
    localparam int ADDR_W      = 17;
    localparam int DATA_W      = 8;
    localparam int OFF_W       = 7;
    localparam int SECT_W      = ADDR_W - OFF_W;
    localparam int CNT_W       = 21;
    localparam int SYNC_STAGES = 2;

    // Load word: {last, offset, data}
    localparam int WORD_W      = 1 + OFF_W + DATA_W;
    localparam int WORD_LAST   = WORD_W - 1;
    localparam int WORD_OFF_LSB = DATA_W;
    localparam int FIFO_DEPTH  = 8;

    // Status bits seen while the part is busy
    localparam int POLL_BIT    = 7;
    localparam int TOGGLE_BIT  = 6;

    // Pin timing in ns
    localparam int T_AS_NS      = 20;
    localparam int T_DS_NS      = 50;
    localparam int T_WP_NS      = 100;
    localparam int T_AH_NS      = 100;
    localparam int T_BLC_MIN_NS = 200;
    localparam int T_BLC_MAX_NS = 300000;
    localparam int T_LP_NS      = 500000;
    localparam int T_WC_NS      = 10000000;
    localparam int T_CLR_NS     = 20000000;
    localparam int T_ACC_NS     = 120;
    localparam int T_OEHP_NS    = 150;
    localparam int T_CS_NS      = 20;
    localparam int T_CP_NS      = 200;
    localparam int T_CH_NS      = 20;

    // Least time: round up, never below one cycle
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Longest time: round down, never below one cycle
    function automatic int cyc_max(input int ns);
        int c;
        c = ns / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int SETUP_CYC   = cyc_min((T_AS_NS > T_DS_NS) ?
                                         T_AS_NS : T_DS_NS);
    localparam int WP_CYC      = cyc_min(T_WP_NS);
    localparam int AH_CYC      = cyc_min(T_AH_NS);
    localparam int BLC_MIN_CYC = cyc_min(T_BLC_MIN_NS);
    localparam int BLC_MAX_CYC = cyc_max(T_BLC_MAX_NS);
    localparam int TLP_CYC     = cyc_max(T_LP_NS);
    localparam int TWC_CYC     = cyc_max(T_WC_NS);
    localparam int CLR_CYC     = cyc_min(T_CLR_NS);
    localparam int RD_CYC      = cyc_min(T_ACC_NS) + SYNC_STAGES + 1;
    localparam int OEHP_CYC    = cyc_min(T_OEHP_NS);
    localparam int CS_CYC      = cyc_min(T_CS_NS);
    localparam int CP_CYC      = cyc_min(T_CP_NS);
    localparam int CH_CYC      = cyc_min(T_CH_NS);

    typedef enum logic [1:0] {
        SFWC_OP_READ  = 2'h0,
        SFWC_OP_WRITE = 2'h1,
        SFWC_OP_CLEAR = 2'h2
    } sfwc_op_t;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_W_WAIT  = 4'h1,
        ST_W_SETUP = 4'h3,
        ST_W_LOW   = 4'h2,
        ST_W_HOLD  = 4'h6,
        ST_P_GAP   = 4'h7,
        ST_P_READ  = 4'h5,
        ST_REST    = 4'h4,
        ST_RD      = 4'hC,
        ST_C_SETUP = 4'h8,
        ST_C_PULSE = 4'h9,
        ST_C_HOLD  = 4'hB,
        ST_C_WAIT  = 4'hA
    } sfwc_state_t;

endpackage

`default_nettype wire

// File: sfwc_stream_if.sv
`default_nettype none

interface sfwc_stream_if #(
    parameter int W = 8
) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

`default_nettype wire

// File: sfwc_fifo.sv
`default_nettype none

module sfwc_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8
) (
    input  wire logic     ref_clk,
    input  wire logic     rst,
    sfwc_stream_if.sink   push,
    sfwc_stream_if.source pop
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Pointers wrap by width, so depth must be a power of two
    if (W < 1 || DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_shape
        $error("sfwc_fifo: W >= 1 and DEPTH a power of two >= 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [PW:0]             cnt;
        logic                    rdy;
    } sfwc_fifo_regs_t;

    sfwc_fifo_regs_t fifo_reg;
    sfwc_fifo_regs_t fifo_next;
    logic            do_push;
    logic            do_pop;

    // Ready is registered so the source never sees a comb path
    assign push.ready = fifo_reg.rdy;
    assign pop.valid  = (fifo_reg.cnt != '0);
    assign pop.data   = fifo_reg.mem[fifo_reg.rp];

    // Next state of the ring
    always_comb begin
        fifo_next = fifo_reg;
        do_push   = push.valid && fifo_reg.rdy;
        do_pop    = pop.valid && pop.ready;
        if (do_push) begin
            fifo_next.mem[fifo_reg.wp] = push.data;
            fifo_next.wp = fifo_reg.wp + 1'b1;
        end
        if (do_pop) begin
            fifo_next.rp = fifo_reg.rp + 1'b1;
        end
        if (do_push && !do_pop) begin
            fifo_next.cnt = fifo_reg.cnt + 1'b1;
        end else if (do_pop && !do_push) begin
            fifo_next.cnt = fifo_reg.cnt - 1'b1;
        end
        fifo_next.rdy = (fifo_next.cnt < (PW + 1)'(DEPTH));
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fifo_reg <= '0;
        end else begin
            fifo_reg <= fifo_next;
        end
    end

endmodule

`default_nettype wire

// File: sfwc_host.sv
// Functional notes
// - Whole load uses one sector address on the upper address bits.
// - Output enable held high whenever write enable and chip enable low.
// - Byte loads spaced 0.2 to 300 us; a longer gap starts programming.
// - Output/chip enable toggled between busy reads; bit 6 inverts each read.
// - Toggle polling never trusts the absolute level of bit 6.
// - Polling reads keep one fixed address throughout.
`default_nettype none

module sfwc_host
    import sfwc_pkg::*;
#(
    parameter int unsigned BLC_MAX = sfwc_pkg::BLC_MAX_CYC,
    parameter int unsigned TLP_MAX = sfwc_pkg::TLP_CYC,
    parameter int unsigned TWC_MAX = sfwc_pkg::TWC_CYC,
    parameter int unsigned CLR_MIN = sfwc_pkg::CLR_CYC
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    input  wire logic                      cmd_valid,
    output var  logic                      cmd_ready,
    input  wire sfwc_pkg::sfwc_op_t        cmd_op,
    input  wire logic [sfwc_pkg::ADDR_W-1:0] cmd_addr,
    input  wire logic                      cmd_toggle,
    input  wire logic                      byte_valid,
    output wire logic                      byte_ready,
    input  wire logic [sfwc_pkg::WORD_W-1:0] byte_word,
    output var  logic                      rsp_valid,
    output var  logic [sfwc_pkg::DATA_W-1:0] rsp_data,
    output var  logic                      rsp_err,
    output var  logic                      rsp_cut,
    output var  logic                      busy,
    output var  logic [sfwc_pkg::ADDR_W-1:0] flash_addr,
    output var  logic                      flash_ce_n,
    output var  logic                      flash_oe_n,
    output var  logic                      flash_we_n,
    output var  logic                      flash_oe_hv,
    output var  logic [sfwc_pkg::DATA_W-1:0] flash_dq_out,
    output var  logic                      flash_dq_oe,
    input  wire logic [sfwc_pkg::DATA_W-1:0] flash_dq_in
);
    import sfwc_pkg::*;

    localparam int unsigned CNT_MAX = (1 << CNT_W) - 1;

    // Counters are CNT_W wide; larger figures cannot be timed
    if (BLC_MAX <= SETUP_CYC + BLC_MIN_CYC || BLC_MAX > CNT_MAX ||
        TLP_MAX + TWC_MAX > CNT_MAX || CLR_MIN < 1 ||
        CLR_MIN > CNT_MAX || BLC_MIN_CYC <= SETUP_CYC) begin : g_bad
        $error("sfwc_host: timing parameter out of range");
    end

    localparam logic [CNT_W-1:0] GAP_MIN  = CNT_W'(BLC_MIN_CYC - SETUP_CYC);
    localparam logic [CNT_W-1:0] GAP_CUT  = CNT_W'(BLC_MAX - SETUP_CYC - 1);
    localparam logic [CNT_W-1:0] POLL_TMO = CNT_W'(TLP_MAX + TWC_MAX);

    typedef struct packed {
        sfwc_state_t         st;
        logic [CNT_W-1:0]    cnt;
        logic [CNT_W-1:0]    gap;
        logic [CNT_W-1:0]    tmo;
        logic                first;
        logic                last;
        logic                toggle_mode;
        logic                have_prev;
        logic                prev6;
        logic                cut;
        logic [SECT_W-1:0]   sector;
        logic [OFF_W-1:0]    last_off;
        logic [DATA_W-1:0]   last_dat;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   dq_out;
        logic                dq_oe;
        logic                ce_n;
        logic                oe_n;
        logic                we_n;
        logic                oe_hv;
        logic [DATA_W-1:0]   sync1;
        logic [DATA_W-1:0]   sync2;
        logic                cmd_ready;
        logic                rsp_valid;
        logic [DATA_W-1:0]   rsp_data;
        logic                rsp_err;
        logic                rsp_cut;
        logic                busy;
    } sfwc_regs_t;

    sfwc_regs_t host_reg;
    sfwc_regs_t host_next;
    logic       pop_take;
    logic       data_ok;
    logic       toggle_ok;

    sfwc_stream_if #(.W(WORD_W)) in_s ();
    sfwc_stream_if #(.W(WORD_W)) out_s ();

    // Load bytes queue here so the user need not meet the byte window
    sfwc_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk (ref_clk),
        .rst     (rst),
        .push    (in_s.sink),
        .pop     (out_s.source)
    );

    assign in_s.valid  = byte_valid;
    assign in_s.data   = byte_word;
    assign byte_ready  = in_s.ready;
    assign out_s.ready = pop_take;

    // Phase timer ends on the cycle it reads one
    function automatic logic phase_done(input logic [CNT_W-1:0] c);
        return (c <= CNT_W'(1));
    endfunction

    // Common end of every command: one-cycle answer, then rest
    function automatic sfwc_regs_t finish(input sfwc_regs_t s,
                                          input logic [DATA_W-1:0] d,
                                          input logic err);
        sfwc_regs_t t;
        t           = s;
        t.rsp_valid = 1'b1;
        t.rsp_data  = d;
        t.rsp_err   = err;
        t.rsp_cut   = s.cut;
        t.ce_n      = 1'b1;
        t.oe_n      = 1'b1;
        t.we_n      = 1'b1;
        t.dq_oe     = 1'b0;
        t.cnt       = CNT_W'(OEHP_CYC);
        t.st        = ST_REST;
        return t;
    endfunction

    // Sequencer
    always_comb begin
        host_next           = host_reg;
        pop_take            = 1'b0;
        host_next.sync1     = flash_dq_in;
        host_next.sync2     = host_reg.sync1;
        host_next.rsp_valid = 1'b0;
        // done once bit 7 matches bit 7 of the last loaded byte
        data_ok   = (host_reg.sync2[POLL_BIT] == host_reg.last_dat[POLL_BIT]);
        toggle_ok = host_reg.have_prev &&
                    (host_reg.sync2[TOGGLE_BIT] == host_reg.prev6);
        if (host_reg.gap != '1) begin
            host_next.gap = host_reg.gap + 1'b1;
        end
        if (host_reg.tmo != '1) begin
            host_next.tmo = host_reg.tmo + 1'b1;
        end
        if (host_reg.cnt != '0) begin
            host_next.cnt = host_reg.cnt - 1'b1;
        end
        case (host_reg.st)
            ST_IDLE: begin
                host_next.cmd_ready = 1'b1;
                host_next.busy      = 1'b0;
                if (cmd_valid && host_reg.cmd_ready) begin
                    host_next.cmd_ready = 1'b0;
                    host_next.busy      = 1'b1;
                    host_next.cut       = 1'b0;
                    case (cmd_op)
                        SFWC_OP_READ: begin
                            host_next.addr = cmd_addr;
                            host_next.ce_n = 1'b0;
                            host_next.oe_n = 1'b0;
                            host_next.cnt  = CNT_W'(RD_CYC);
                            host_next.st   = ST_RD;
                        end
                        SFWC_OP_WRITE: begin
                            // sector latched for the whole load
                            host_next.sector = cmd_addr[ADDR_W-1:OFF_W];
                            host_next.first  = 1'b1;
                            host_next.toggle_mode = cmd_toggle;
                            host_next.st     = ST_W_WAIT;
                        end
                        SFWC_OP_CLEAR: begin
                            // raise 12 V on OE first
                            host_next.oe_hv = 1'b1;
                            host_next.oe_n  = 1'b1;
                            host_next.cnt   = CNT_W'(CS_CYC);
                            host_next.st    = ST_C_SETUP;
                        end
                        default: begin
                            host_next = finish(host_next, '0, 1'b1);
                        end
                    endcase
                end
            end
            ST_W_WAIT: begin
                // next fall no sooner than the least spacing
                if (out_s.valid && (host_reg.first ||
                                    host_reg.gap >= GAP_MIN)) begin
                    pop_take           = 1'b1;
                    host_next.addr     = {host_reg.sector,
                        out_s.data[WORD_OFF_LSB +: OFF_W]};
                    host_next.dq_out   = out_s.data[DATA_W-1:0];
                    host_next.dq_oe    = 1'b1;
                    host_next.last     = out_s.data[WORD_LAST];
                    host_next.last_off = out_s.data[WORD_OFF_LSB +: OFF_W];
                    host_next.last_dat = out_s.data[DATA_W-1:0];
                    host_next.cnt      = CNT_W'(SETUP_CYC);
                    host_next.st       = ST_W_SETUP;
                // starved past the window, part starts on its own
                end else if (!host_reg.first && host_reg.gap >= GAP_CUT) begin
                    host_next.cut       = 1'b1;
                    host_next.addr      = {host_reg.sector, host_reg.last_off};
                    host_next.have_prev = 1'b0;
                    host_next.tmo       = '0;
                    host_next.cnt       = CNT_W'(OEHP_CYC);
                    host_next.st        = ST_P_GAP;
                end
            end
            ST_W_SETUP: begin
                if (phase_done(host_reg.cnt)) begin
                    // OE stays high while both strobes are low
                    host_next.oe_n  = 1'b1;
                    host_next.ce_n  = 1'b0;
                    host_next.we_n  = 1'b0;
                    host_next.gap   = '0;
                    host_next.first = 1'b0;
                    host_next.cnt   = CNT_W'(WP_CYC);
                    host_next.st    = ST_W_LOW;
                end
            end
            ST_W_LOW: begin
                if (phase_done(host_reg.cnt)) begin
                    host_next.ce_n = 1'b1;
                    host_next.we_n = 1'b1;
                    host_next.cnt  = CNT_W'(AH_CYC);
                    host_next.st   = ST_W_HOLD;
                end
            end
            ST_W_HOLD: begin
                if (phase_done(host_reg.cnt)) begin
                    host_next.dq_oe = 1'b0;
                    if (host_reg.last) begin
                        // poll the last loaded address only
                        host_next.have_prev = 1'b0;
                        host_next.tmo       = '0;
                        host_next.cnt       = CNT_W'(OEHP_CYC);
                        host_next.st        = ST_P_GAP;
                    end else begin
                        host_next.st = ST_W_WAIT;
                    end
                end
            end
            ST_P_GAP: begin
                // OE and CE high between polling reads
                if (phase_done(host_reg.cnt)) begin
                    host_next.ce_n = 1'b0;
                    host_next.oe_n = 1'b0;
                    host_next.cnt  = CNT_W'(RD_CYC);
                    host_next.st   = ST_P_READ;
                end
            end
            ST_P_READ: begin
                if (phase_done(host_reg.cnt)) begin
                    // each read ends with a strobe toggle
                    host_next.ce_n      = 1'b1;
                    host_next.oe_n      = 1'b1;
                    host_next.prev6     = host_reg.sync2[TOGGLE_BIT];
                    host_next.have_prev = 1'b1;
                    host_next.cnt       = CNT_W'(OEHP_CYC);
                    host_next.st        = ST_P_GAP;
                    if (host_reg.toggle_mode ? toggle_ok : data_ok) begin
                        host_next = finish(host_reg, host_reg.sync2, 1'b0);
                    // status and program time bound the wait
                    end else if (host_reg.tmo >= POLL_TMO) begin
                        host_next = finish(host_reg, host_reg.sync2, 1'b1);
                    end
                end
            end
            ST_RD: begin
                if (phase_done(host_reg.cnt)) begin
                    host_next = finish(host_reg, host_reg.sync2, 1'b0);
                end
            end
            ST_C_SETUP: begin
                if (phase_done(host_reg.cnt)) begin
                    // both strobes low under 12 V
                    host_next.ce_n = 1'b0;
                    host_next.we_n = 1'b0;
                    host_next.cnt  = CNT_W'(CP_CYC);
                    host_next.st   = ST_C_PULSE;
                end
            end
            ST_C_PULSE: begin
                if (phase_done(host_reg.cnt)) begin
                    host_next.ce_n = 1'b1;
                    host_next.we_n = 1'b1;
                    host_next.cnt  = CNT_W'(CH_CYC);
                    host_next.st   = ST_C_HOLD;
                end
            end
            ST_C_HOLD: begin
                if (phase_done(host_reg.cnt)) begin
                    host_next.oe_hv = 1'b0;
                    host_next.cnt   = CNT_W'(CLR_MIN);
                    host_next.st    = ST_C_WAIT;
                end
            end
            ST_C_WAIT: begin
                // idle pins until the part's timer is done
                if (phase_done(host_reg.cnt)) begin
                    host_next = finish(host_reg, '1, 1'b0);
                end
            end
            ST_REST: begin
                // Gives the part its output float time before reuse
                if (phase_done(host_reg.cnt)) begin
                    host_next.cmd_ready = 1'b1;
                    host_next.busy      = 1'b0;
                    host_next.st        = ST_IDLE;
                end
            end
            default: begin
                host_next.st = ST_IDLE;
            end
        endcase
    end

    // State register; pins parked inactive in reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            host_reg      <= '0;
            host_reg.ce_n <= 1'b1;
            host_reg.oe_n <= 1'b1;
            host_reg.we_n <= 1'b1;
        end else begin
            host_reg <= host_next;
        end
    end

    assign cmd_ready    = host_reg.cmd_ready;
    assign rsp_valid    = host_reg.rsp_valid;
    assign rsp_data     = host_reg.rsp_data;
    assign rsp_err      = host_reg.rsp_err;
    assign rsp_cut      = host_reg.rsp_cut;
    assign busy         = host_reg.busy;
    assign flash_addr   = host_reg.addr;
    assign flash_ce_n   = host_reg.ce_n;
    assign flash_oe_n   = host_reg.oe_n;
    assign flash_we_n   = host_reg.we_n;
    assign flash_oe_hv  = host_reg.oe_hv;
    assign flash_dq_out = host_reg.dq_out;
    assign flash_dq_oe  = host_reg.dq_oe;

endmodule

`default_nettype wire

// File: sfwc_host_properties.sv
`default_nettype none
module sfwc_host_properties (
    input wire logic                        ref_clk,
    input wire logic                        rst,
    input wire logic                        busy,
    input wire logic [sfwc_pkg::ADDR_W-1:0] flash_addr,
    input wire logic                        flash_ce_n,
    input wire logic                        flash_oe_n,
    input wire logic                        flash_we_n,
    input wire logic                        flash_oe_hv
);
    import sfwc_pkg::*;
    logic [ADDR_W-1:0] wa_reg;
    logic [7:0]        gap_reg;
    logic              have_reg;
    logic              we_q;
    wire logic         fall = we_q && !flash_we_n;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Last strobed address, cycles since the last fall
    always_ff @(posedge ref_clk) begin
        we_q <= flash_we_n;
        if (rst) begin
            gap_reg <= 8'hFF;
            have_reg <= 1'b0;
        end else if (fall) begin
            gap_reg <= 8'h01;
            have_reg <= 1'b1;
            wa_reg <= flash_addr;
        end else begin
            gap_reg <= (gap_reg == 8'hFF) ? gap_reg : gap_reg + 8'h01;
            have_reg <= have_reg && busy;
        end
    end
    sequence s_hv_up;
        $rose(flash_oe_hv);
    endsequence
    sequence s_clr_strobe;
        flash_oe_hv && !flash_ce_n && !flash_we_n;
    endsequence
    a_oe_we_excl: assert property (
        !(!flash_we_n && !flash_ce_n && !flash_oe_n))
        else $error("oe low in write strobe");
    a_sector_steady: assert property (
        fall && have_reg |->
        flash_addr[ADDR_W-1:OFF_W] == wa_reg[ADDR_W-1:OFF_W])
        else $error("sector moved in load");
    a_load_spacing: assert property (
        fall |-> gap_reg >= BLC_MIN_CYC)
        else $error("loads too close");
    a_toggle_gap: assert property (
        $rose(flash_oe_n) && have_reg |-> flash_oe_n [*8])
        else $error("oe high pulse short");
    a_poll_addr: assert property (
        $fell(flash_oe_n) && have_reg |-> flash_addr == wa_reg)
        else $error("poll address moved");
    a_clear_entry: assert property (
        s_hv_up |-> ##[1:4] s_clr_strobe)
        else $error("clear strobe missing");
endmodule
bind sfwc_host sfwc_host_properties sfwc_host_properties_inst (.ref_clk,
    .rst, .busy, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .flash_oe_hv);
`default_nettype wire

// File: sfwc_flash_model.sv
`default_nettype none
module sfwc_flash_model #(
    parameter int GAP  = 60,
    parameter int PROG = 120,
    parameter int CLR  = 40
) (
    input  wire logic        ref_clk,
    input  wire logic [16:0] addr,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        hv,
    input  wire logic [7:0]  dq,
    output var  logic [7:0]  dq_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [int];
    logic [7:0] page [int];
    logic [7:0] blank = 8'h00;
    logic [7:0] last_d = 8'h00;
    logic [9:0] sec = 10'h000;
    logic       tog = 1'b0;
    logic       wr_q = 1'b0;
    logic       rd_q = 1'b0;
    int         ph = 0;
    int         cnt = 0;
    wire logic  wr = !ce_n && !we_n && !hv;
    wire logic  rd = !ce_n && !oe_n;
    // Load, program and clear run on the part's own timer
    always @(posedge ref_clk) begin
        wr_q <= wr;
        rd_q <= rd;
        cnt <= cnt + 1;
        if (rd_q && !rd && ph != 0)
            tog <= !tog;
        if (wr_q && !wr) begin
            page[addr[6:0]] = dq;
            sec <= addr[16:7];
            last_d <= dq;
            ph <= 1;
            cnt <= 0;
        end else if (ph == 1 && cnt == GAP) begin
            ph <= 2;
            cnt <= 0;
        end else if (ph == 2 && cnt == PROG) begin
            for (int i = 0; i < 128; i++)
                mem[{sec, i[6:0]}] = page.exists(i) ? page[i] : 8'hFF;
            page.delete();
            ph <= 0;
        end else if (ph == 0 && !ce_n && !we_n && hv) begin
            ph <= 3;
            cnt <= 0;
        end else if (ph == 3 && cnt == CLR) begin
            mem.delete();
            blank <= 8'hFF;
            ph <= 0;
        end
    end
    // status at once; deselected bus never holds a value
    always @* begin
        if (!rd)
            dq_rd = {8{ref_clk}} ^ 8'h5A;
        else if (ph != 0)
            dq_rd = {~last_d[7], tog, 6'h00};
        else
            dq_rd = mem.exists(addr) ? mem[addr] : blank;
    end
endmodule
`default_nettype wire

// File: sfwc_host_bench.sv
`default_nettype none
module sfwc_host_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import sfwc_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_toggle = 1'b0;
    logic byte_valid = 1'b0, cmd_ready, byte_ready, rsp_valid, rsp_err;
    logic flash_ce_n, flash_oe_n, flash_we_n, flash_oe_hv, flash_dq_oe;
    logic rsp_cut, busy;
    sfwc_op_t cmd_op = SFWC_OP_READ;
    logic [ADDR_W-1:0] cmd_addr = '0, flash_addr;
    logic [WORD_W-1:0] byte_word = '0;
    logic [DATA_W-1:0] rsp_data, flash_dq_out, dq_rd;
    wire logic [DATA_W-1:0] flash_dq_in = flash_dq_oe ? flash_dq_out : dq_rd;
    int n_errors = 0;
    int checks_done = 0;
    // Short counts keep the run small
    sfwc_host #(.BLC_MAX(100), .TLP_MAX(50), .TWC_MAX(200), .CLR_MIN(50))
        sfwc_host_inst (.ref_clk, .rst, .cmd_valid, .cmd_ready, .cmd_op,
        .cmd_addr, .cmd_toggle, .byte_valid, .byte_ready, .byte_word,
        .rsp_valid, .rsp_data, .rsp_err, .rsp_cut, .busy, .flash_addr,
        .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_oe_hv, .flash_dq_out,
        .flash_dq_oe, .flash_dq_in);
    sfwc_flash_model sfwc_flash_model_inst (.ref_clk, .addr(flash_addr),
        .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
        .hv(flash_oe_hv), .dq(flash_dq_in), .dq_rd);
    initial forever #5 ref_clk = ~ref_clk;
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    // Bounded wait at falling edges
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1) begin
            @(negedge ref_clk);
            n++;
            if (n > 3000) begin
                n_errors++;
                tally_and_finish();
            end
        end
    endtask
    task automatic run(sfwc_op_t op, logic [16:0] a, logic t);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = a;
        cmd_toggle = t;
        wait_hi(cmd_ready);
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        wait_hi(rsp_valid);
    endtask
    task automatic rd(logic [16:0] a, logic [7:0] exp, string what);
        run(SFWC_OP_READ, a, 1'b0);
        check(what, exp, rsp_data);
    endtask
    // Valid held between words
    task automatic push(logic [15:0] w);
        byte_valid = 1'b1;
        byte_word = w;
        wait_hi(byte_ready);
        @(negedge ref_clk);
    endtask
    task automatic t_poll_write();
        for (int i = 0; i < 8; i++)
            push({i == 7, i[6:0], 8'h10 + i[7:0]});
        byte_valid = 1'b0;
        check("fifo full ready", 8'h00, {7'h00, byte_ready});
        run(SFWC_OP_WRITE, {10'h005, 7'h00}, 1'b0);
        check("poll err", 8'h00, {7'h00, rsp_err});
        check("poll data", 8'h17, rsp_data);
        rd({10'h005, 7'h03}, 8'h13, "loaded byte");
        rd({10'h005, 7'h40}, 8'hFF, "unloaded byte");
        $display("poll write done");
    endtask
    task automatic t_toggle_write();
        push({1'b0, 7'h05, 8'h5A});
        byte_valid = 1'b0;
        run(SFWC_OP_WRITE, {10'h007, 7'h00}, 1'b1);
        check("toggle err", 8'h00, {7'h00, rsp_err});
        check("cut", 8'h01, {7'h00, rsp_cut});
        rd({10'h007, 7'h05}, 8'h5A, "toggle byte");
        $display("toggle write done");
    endtask
    task automatic t_bad_op();
        run(sfwc_op_t'(2'h3), '0, 1'b0);
        check("bad op err", 8'h01, {7'h00, rsp_err});
        check("busy", 8'h01, {7'h00, busy});
        $display("bad op done");
    endtask
    task automatic t_clear();
        run(SFWC_OP_CLEAR, '0, 1'b0);
        check("clear data", 8'hFF, rsp_data);
        rd({10'h005, 7'h03}, 8'hFF, "cleared byte");
        rd({10'h007, 7'h05}, 8'hFF, "cleared byte 2");
        $display("clear done");
    endtask
    // Five reset cycles, then scenarios
    initial begin
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        t_poll_write();
        t_toggle_write();
        t_bad_op();
        t_clear();
        tally_and_finish();
    end
endmodule
`default_nettype wire
